// File: rtl/swoq_defines.vh
/*
 * Shared constants for the statistics window overlap qualifier:
 * register offsets, field positions, reset values and sensor size.
 * Assumes inclusion by the design and bench files of this block only.
 */
`ifndef SWOQ_DEFINES_VH
`define SWOQ_DEFINES_VH

// Register byte offsets, one aligned 32-bit word each
`define SWOQ_OFF_CTRL       8'h00
`define SWOQ_OFF_STATUS     8'h04
`define SWOQ_OFF_IMG_COL    8'h08
`define SWOQ_OFF_IMG_LINE   8'h0C
`define SWOQ_OFF_IMG_COLS   8'h10
`define SWOQ_OFF_IMG_LINES  8'h14
`define SWOQ_OFF_W1_COL     8'h20
`define SWOQ_OFF_W1_LINE    8'h24
`define SWOQ_OFF_W1_COLS    8'h28
`define SWOQ_OFF_W1_LINES   8'h2C
`define SWOQ_OFF_W1_ASSIGN  8'h30
`define SWOQ_OFF_W2_COL     8'h40
`define SWOQ_OFF_W2_LINE    8'h44
`define SWOQ_OFF_W2_COLS    8'h48
`define SWOQ_OFF_W2_LINES   8'h4C
`define SWOQ_OFF_W2_ASSIGN  8'h50

// Assignment fields: bit 0 intensity (gain and exposure), bit 1 white balance
`define SWOQ_ASN_INTENSITY  0
`define SWOQ_ASN_WHITEBAL   1
`define SWOQ_ASN_W1_RST     2'h1
`define SWOQ_ASN_W2_RST     2'h2

// Control fields
`define SWOQ_CTRL_BINNING   0

// Sensor dimensions, the default window extent
`define SWOQ_SENSOR_COLS    2048
`define SWOQ_SENSOR_LINES   1088

// AXI responses
`define SWOQ_RESP_OKAY      2'h0
`define SWOQ_RESP_SLVERR    2'h2

`endif

// File: rtl/swoq_window_hit.v
/*
 * One statistics window membership test against the current pixel.
 * Assumes column and line counts in the same units as the window.
 */
`timescale 1ns/1ps

module swoq_window_hit #(
   parameter CW = 12
) (
   // Current pixel position
   input wire [CW-1:0] col,
   input wire [CW-1:0] line,
   // Window
   input wire [CW-1:0] start_col,
   input wire [CW-1:0] start_line,
   input wire [CW-1:0] cols,
   input wire [CW-1:0] lines,
   // Result
   output wire hit,
   output wire empty
);

   // Widen by one bit so offset plus extent cannot wrap
   wire [CW:0] end_col;
   wire [CW:0] end_line;
   assign end_col = {1'b0, start_col} + {1'b0, cols};
   assign end_line = {1'b0, start_line} + {1'b0, lines};

   // Inclusive start, exclusive end on both axes
   assign hit = ({1'b0, col} >= {1'b0, start_col}) && ({1'b0, col} < end_col) &&
                ({1'b0, line} >= {1'b0, start_line}) && ({1'b0, line} < end_line);
   assign empty = (cols == {CW{1'b0}}) || (lines == {CW{1'b0}});

endmodule // swoq_window_hit

// File: rtl/swoq_qualifier.v
/*
 * Statistics window overlap qualifier: marks each streamed pixel that lies
 * in both the captured region and a statistics window, per auto function.
 * Assumes an AXI4-Lite master on aclk and a pixel stream from logic on the
 * same clock, framed by frame and line starts, already binned when binning
 * is active.
 */
`timescale 1ns/1ps
`include "swoq_defines.vh"

module swoq_qualifier #(
   parameter CW = 12,
   parameter SENSOR_COLS = `SWOQ_SENSOR_COLS,
   parameter SENSOR_LINES = `SWOQ_SENSOR_LINES
) (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // AXI4-Lite write address
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   // AXI4-Lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   // AXI4-Lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read address
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   // AXI4-Lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // Pixel stream in
   input wire pix_valid,
   input wire pix_frame_start,
   input wire pix_line_start,
   // Qualified pixel flags out, one cycle after the pixel
   output reg pix_valid_q,
   output reg intensity_use_q,
   output reg whitebal_use_q,
   // Per frame: whether each function had any overlap; then the binning control bit
   output reg intensity_active_q,
   output reg whitebal_active_q,
   output reg binning_q
);

   ////////////////////////////////////////////////////////////////////////
   // Configuration registers

   localparam [CW-1:0] RST_COLS = SENSOR_COLS[CW-1:0];
   localparam [CW-1:0] RST_LINES = SENSOR_LINES[CW-1:0];

   reg [CW-1:0] img_col_q, img_line_q, img_cols_q, img_lines_q;
   reg [CW-1:0] w1_col_q, w1_line_q, w1_cols_q, w1_lines_q;
   reg [CW-1:0] w2_col_q, w2_line_q, w2_cols_q, w2_lines_q;
   reg [1:0] w1_asn_q, w2_asn_q;

   // Write channel state
   reg [7:0] awaddr_q;
   reg aw_held_q;
   reg [31:0] wdata_q;
   reg [3:0] wstrb_q;
   reg w_held_q;
   wire do_write;
   wire [CW-1:0] wval;

   assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;
   // Registers take the low CW bits of the word, only when the low lanes are enabled
   assign wval = wdata_q[CW-1:0];

   ////////////////////////////////////////////////////////////////////////
   // Write path; address and data accepted in either order

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `SWOQ_RESP_OKAY;
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end else begin
         s_axi_awready <= !aw_held_q && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !w_held_q && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            case (awaddr_q)
               `SWOQ_OFF_CTRL, `SWOQ_OFF_IMG_COL, `SWOQ_OFF_IMG_LINE,
               `SWOQ_OFF_IMG_COLS, `SWOQ_OFF_IMG_LINES,
               `SWOQ_OFF_W1_COL, `SWOQ_OFF_W1_LINE, `SWOQ_OFF_W1_COLS,
               `SWOQ_OFF_W1_LINES, `SWOQ_OFF_W1_ASSIGN,
               `SWOQ_OFF_W2_COL, `SWOQ_OFF_W2_LINE, `SWOQ_OFF_W2_COLS,
               `SWOQ_OFF_W2_LINES, `SWOQ_OFF_W2_ASSIGN:
                  s_axi_bresp <= `SWOQ_RESP_OKAY;
               default:
                  s_axi_bresp <= `SWOQ_RESP_SLVERR;
            endcase
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Register file; each setting writable alone, lower two lanes carry it
   always @(posedge aclk) begin
      if (!aresetn) begin
         binning_q <= 1'b0;
         img_col_q <= {CW{1'b0}};
         img_line_q <= {CW{1'b0}};
         img_cols_q <= RST_COLS;
         img_lines_q <= RST_LINES;
         w1_col_q <= {CW{1'b0}};
         w1_line_q <= {CW{1'b0}};
         w1_cols_q <= RST_COLS;
         w1_lines_q <= RST_LINES;
         w2_col_q <= {CW{1'b0}};
         w2_line_q <= {CW{1'b0}};
         w2_cols_q <= RST_COLS;
         w2_lines_q <= RST_LINES;
         w1_asn_q <= `SWOQ_ASN_W1_RST;
         w2_asn_q <= `SWOQ_ASN_W2_RST;
      end else if (do_write && (wstrb_q[1:0] == 2'h3)) begin
         case (awaddr_q)
            `SWOQ_OFF_CTRL: binning_q <= wdata_q[`SWOQ_CTRL_BINNING];
            `SWOQ_OFF_IMG_COL: img_col_q <= wval;
            `SWOQ_OFF_IMG_LINE: img_line_q <= wval;
            `SWOQ_OFF_IMG_COLS: img_cols_q <= wval;
            `SWOQ_OFF_IMG_LINES: img_lines_q <= wval;
            `SWOQ_OFF_W1_COL: w1_col_q <= wval;
            `SWOQ_OFF_W1_LINE: w1_line_q <= wval;
            `SWOQ_OFF_W1_COLS: w1_cols_q <= wval;
            `SWOQ_OFF_W1_LINES: w1_lines_q <= wval;
            `SWOQ_OFF_W1_ASSIGN: w1_asn_q <= wdata_q[1:0];
            `SWOQ_OFF_W2_COL: w2_col_q <= wval;
            `SWOQ_OFF_W2_LINE: w2_line_q <= wval;
            `SWOQ_OFF_W2_COLS: w2_cols_q <= wval;
            `SWOQ_OFF_W2_LINES: w2_lines_q <= wval;
            `SWOQ_OFF_W2_ASSIGN: w2_asn_q <= wdata_q[1:0];
            default: binning_q <= binning_q;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read path; one cycle after the address is taken

   reg [31:0] rd_d;
   reg rd_ok_d;
   reg [31:0] status_w;

   always @* begin
      rd_ok_d = 1'b1;
      rd_d = 32'h0000_0000;
      case (s_axi_araddr)
         `SWOQ_OFF_CTRL: rd_d[0] = binning_q;
         `SWOQ_OFF_STATUS: rd_d = status_w;
         `SWOQ_OFF_IMG_COL: rd_d[CW-1:0] = img_col_q;
         `SWOQ_OFF_IMG_LINE: rd_d[CW-1:0] = img_line_q;
         `SWOQ_OFF_IMG_COLS: rd_d[CW-1:0] = img_cols_q;
         `SWOQ_OFF_IMG_LINES: rd_d[CW-1:0] = img_lines_q;
         `SWOQ_OFF_W1_COL: rd_d[CW-1:0] = w1_col_q;
         `SWOQ_OFF_W1_LINE: rd_d[CW-1:0] = w1_line_q;
         `SWOQ_OFF_W1_COLS: rd_d[CW-1:0] = w1_cols_q;
         `SWOQ_OFF_W1_LINES: rd_d[CW-1:0] = w1_lines_q;
         `SWOQ_OFF_W1_ASSIGN: rd_d[1:0] = w1_asn_q;
         `SWOQ_OFF_W2_COL: rd_d[CW-1:0] = w2_col_q;
         `SWOQ_OFF_W2_LINE: rd_d[CW-1:0] = w2_line_q;
         `SWOQ_OFF_W2_COLS: rd_d[CW-1:0] = w2_cols_q;
         `SWOQ_OFF_W2_LINES: rd_d[CW-1:0] = w2_lines_q;
         `SWOQ_OFF_W2_ASSIGN: rd_d[1:0] = w2_asn_q;
         default: rd_ok_d = 1'b0;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `SWOQ_RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_d;
            s_axi_rresp <= rd_ok_d ? `SWOQ_RESP_OKAY : `SWOQ_RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pixel position counters, origin at the top-left corner

   reg [CW-1:0] col_q, line_q;
   reg [CW-1:0] cur_col, cur_line;

   // Start markers reset the position on the marked pixel itself
   always @* begin
      cur_col = col_q;
      cur_line = line_q;
      if (pix_frame_start) begin
         cur_col = {CW{1'b0}};
         cur_line = {CW{1'b0}};
      end else if (pix_line_start) begin
         cur_col = {CW{1'b0}};
         cur_line = line_q + {{(CW-1){1'b0}}, 1'b1};
      end
   end

   // Counters run in stream units, which are binned units when binning is on
   always @(posedge aclk) begin
      if (!aresetn) begin
         col_q <= {CW{1'b0}};
         line_q <= {CW{1'b0}};
      end else if (pix_valid) begin
         col_q <= cur_col + {{(CW-1){1'b0}}, 1'b1};
         line_q <= cur_line;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Membership tests

   wire img_hit, w1_hit, w2_hit;
   wire img_empty, w1_empty, w2_empty;

   swoq_window_hit #(.CW(CW)) u_img (
      .col(cur_col), .line(cur_line),
      .start_col(img_col_q), .start_line(img_line_q),
      .cols(img_cols_q), .lines(img_lines_q),
      .hit(img_hit), .empty(img_empty)
   );

   swoq_window_hit #(.CW(CW)) u_w1 (
      .col(cur_col), .line(cur_line),
      .start_col(w1_col_q), .start_line(w1_line_q),
      .cols(w1_cols_q), .lines(w1_lines_q),
      .hit(w1_hit), .empty(w1_empty)
   );

   swoq_window_hit #(.CW(CW)) u_w2 (
      .col(cur_col), .line(cur_line),
      .start_col(w2_col_q), .start_line(w2_line_q),
      .cols(w2_cols_q), .lines(w2_lines_q),
      .hit(w2_hit), .empty(w2_empty)
   );

   // Intersection covers the inside, enclosing and partial cases alike
   wire in1, in2, int_d, wb_d;
   assign in1 = pix_valid && img_hit && w1_hit;
   assign in2 = pix_valid && img_hit && w2_hit;
   // One intensity bit drives both gain and exposure
   assign int_d = (in1 && w1_asn_q[`SWOQ_ASN_INTENSITY]) ||
                  (in2 && w2_asn_q[`SWOQ_ASN_INTENSITY]);
   assign wb_d = (in1 && w1_asn_q[`SWOQ_ASN_WHITEBAL]) ||
                 (in2 && w2_asn_q[`SWOQ_ASN_WHITEBAL]);

   ////////////////////////////////////////////////////////////////////////
   // Outputs and per-frame overlap tracking

   reg int_seen_q, wb_seen_q;

   // Active flags update at frame start from the previous frame; a function
   // with no overlapping pixel leaves its manual value untouched downstream
   always @(posedge aclk) begin
      if (!aresetn) begin
         pix_valid_q <= 1'b0;
         intensity_use_q <= 1'b0;
         whitebal_use_q <= 1'b0;
         int_seen_q <= 1'b0;
         wb_seen_q <= 1'b0;
         intensity_active_q <= 1'b0;
         whitebal_active_q <= 1'b0;
      end else begin
         pix_valid_q <= pix_valid;
         intensity_use_q <= int_d;
         whitebal_use_q <= wb_d;
         if (pix_valid && pix_frame_start) begin
            intensity_active_q <= int_seen_q;
            whitebal_active_q <= wb_seen_q;
            int_seen_q <= int_d;
            wb_seen_q <= wb_d;
         end else begin
            int_seen_q <= int_seen_q | int_d;
            wb_seen_q <= wb_seen_q | wb_d;
         end
      end
   end

   // Status shows window emptiness and last frame activity
   always @* begin
      status_w = 32'h0000_0000;
      status_w[0] = intensity_active_q;
      status_w[1] = whitebal_active_q;
      status_w[2] = img_empty;
      status_w[3] = w1_empty;
      status_w[4] = w2_empty;
   end

endmodule // swoq_qualifier

// File: testbench/swoq_qualifier_props.sv
/* Checker on the qualifier ports: stream flag timing and bus answer holds.
   Assumes a bind to swoq_qualifier, one clock, synchronous low reset. */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
module swoq_qualifier_props (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // Bus answers
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   // Pixel stream and flags
   input wire pix_valid,
   input wire pix_frame_start,
   input wire pix_valid_q,
   input wire intensity_use_q,
   input wire whitebal_use_q,
   input wire intensity_active_q,
   input wire whitebal_active_q
);
   // One domain, so one clocking and one disable
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_flag_one_late: assert property (pix_valid_q == $past(pix_valid))
      else $error("pixel flag not one cycle behind");
   a_int_needs_pixel: assert property (intensity_use_q |-> pix_valid_q)
      else $error("intensity flag without pixel");
   a_wb_needs_pixel: assert property (whitebal_use_q |-> pix_valid_q)
      else $error("white balance flag without pixel");
   a_active_at_start: assert property (
      ($changed(intensity_active_q) || $changed(whitebal_active_q))
      |-> $past(pix_valid && pix_frame_start)) else $error("active moved mid frame");
   a_bvalid_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write answer dropped early");
   a_rdata_stands: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped or changed");
   a_read_answer: assert property (s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   a_arready_pulse: assert property (s_axi_arready |=> !s_axi_arready)
      else $error("read address taken twice");
endmodule // swoq_qualifier_props

// File: testbench/swoq_pix_model.sv
/* Pixel source: one frame of COLS by LINES pixels per go pulse, with stalls.
   Assumes go only while idle; stall comes from the bench. */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
module swoq_pix_model #(
   parameter COLS = 24,
   parameter LINES = 10
) (
   // Clock and control
   input wire aclk,
   input wire aresetn,
   input wire go,
   input wire stall,
   // Stream
   output reg pix_valid,
   output reg pix_frame_start,
   output reg pix_line_start,
   output reg busy
);
   integer c;
   integer l;
   // Raster walk; gaps keep the consumer honest about valid
   always @(posedge aclk) begin
      pix_valid <= 1'b0;
      pix_frame_start <= 1'b0;
      pix_line_start <= 1'b0;
      if (!aresetn) begin
         busy <= 1'b0;
      end else if (go && !busy) begin
         busy <= 1'b1;
         c = 0;
         l = 0;
      end else if (busy && !stall) begin
         pix_valid <= 1'b1;
         pix_frame_start <= (c == 0 && l == 0); // Frame start first
         pix_line_start <= (c == 0 && l != 0);
         c = c + 1;
         if (c == COLS) begin
            c = 0;
            l = l + 1;
            if (l == LINES) busy <= 1'b0;
         end
      end
   end
endmodule // swoq_pix_model

// File: testbench/swoq_qualifier_bench.sv
/* Bench: sets windows over the bus, streams frames, scores every flag.
   Assumes the design, its defines and the pixel model are compiled. */
`timescale 1ns/1ps
`include "swoq_defines.vh"
////////////////////////////////////////////////////////////////////////////
module swoq_qualifier_bench;
   logic aclk, aresetn, go, stall, busy, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready, pix_valid, pix_frame_start, pix_line_start;
   logic pix_valid_q, intensity_use_q, whitebal_use_q, intensity_active_q;
   logic whitebal_active_q, binning_q, ei, ew, h1, h2, prv_i, prv_w;
   // Per-frame activity, owned by the scoreboard alone
   logic act_i = 1'b0;
   logic act_w = 1'b0;
   logic [3:0] s_axi_wstrb, wst;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [1:0] s_axi_bresp, s_axi_rresp, nt;
   logic [12:0] sh [3][4];
   logic [1:0] asn [2];
   logic [1:0] note_q [$];
   logic [15:0] rnd = 16'h0494;
   logic [12:0] col, line;
   integer failures, check_count, k;
   swoq_qualifier DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_rdata(s_axi_rdata),
      .s_axi_arready(s_axi_arready), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .pix_valid(pix_valid), .pix_frame_start(pix_frame_start),
      .pix_line_start(pix_line_start), .pix_valid_q(pix_valid_q), .binning_q(binning_q),
      .intensity_use_q(intensity_use_q), .whitebal_use_q(whitebal_use_q),
      .intensity_active_q(intensity_active_q), .whitebal_active_q(whitebal_active_q));
   swoq_pix_model u_src (.aclk(aclk), .aresetn(aresetn), .go(go), .stall(stall),
      .pix_valid(pix_valid), .pix_frame_start(pix_frame_start),
      .pix_line_start(pix_line_start), .busy(busy));
   function automatic logic [15:0] nx(input logic [15:0] x);
      nx = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   function automatic logic inr(input logic [12:0] p, s, n);
      inr = (p >= s) && (p < s + n); // Inclusive start, exclusive end
   endfunction
   // A zero extent on either axis leaves a region empty
   function automatic logic emp(input int i);
      emp = (sh[i][2] == 13'h0) || (sh[i][3] == 13'h0);
   endfunction
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count = check_count + 1;
      if (g !== e) begin
         failures = failures + 1;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task tally_and_finish;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Bus master; ready raised late so the answer has to stand
   task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw, w;
      @(posedge aclk);
      aw = 1'b1;
      w = 1'b1;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= wst;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (aw || w) begin
         @(posedge aclk);
         if (s_axi_awready) begin
            aw = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wready) begin
            w = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
      end
      while (!s_axi_bvalid) @(posedge aclk);
      s_axi_bready <= 1'b1;
      @(posedge aclk);
      chk("bresp", er, s_axi_bresp);
      s_axi_bready <= 1'b0;
   endtask
   task axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      @(posedge aclk);
      while (!s_axi_arready) @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      while (!s_axi_rvalid) @(posedge aclk);
      s_axi_rready <= 1'b1;
      @(posedge aclk);
      chk("rdata", ed, s_axi_rdata);
      chk("rresp", er, s_axi_rresp);
      s_axi_rready <= 1'b0;
   endtask
   // Region 0 is the captured region, 1 and 2 the windows
   task setw(input int i, input logic [12:0] c, l, w, h);
      logic [7:0] b;
      b = (i == 0) ? `SWOQ_OFF_IMG_COL : (i == 1) ? `SWOQ_OFF_W1_COL : `SWOQ_OFF_W2_COL;
      sh[i] = '{c, l, w, h};
      axi_wr(b, {19'h0, c}, `SWOQ_RESP_OKAY);
      axi_wr(b + 8'h04, {19'h0, l}, `SWOQ_RESP_OKAY);
      axi_wr(b + 8'h08, {19'h0, w}, `SWOQ_RESP_OKAY);
      axi_wr(b + 8'h0C, {19'h0, h}, `SWOQ_RESP_OKAY);
   endtask
   task seta(input int i, input logic [1:0] v);
      asn[i] = v;
      axi_wr(i == 1 ? `SWOQ_OFF_W2_ASSIGN : `SWOQ_OFF_W1_ASSIGN, {30'h0, v}, 2'h0);
   endtask
   // Active flags report the frame before, so check them early
   task run_frame;
      go <= 1'b1;
      @(posedge aclk);
      go <= 1'b0;
      while (!pix_valid_q) @(posedge aclk);
      @(posedge aclk);
      chk("intensity_active", prv_i, intensity_active_q);
      chk("whitebal_active", prv_w, whitebal_active_q);
      while (busy) @(posedge aclk);
      repeat (3) @(posedge aclk);
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Scoreboard: note each pixel's expected flags, score one cycle on
   always @(posedge aclk) begin
      if (aresetn && pix_valid_q) begin
         nt = note_q.pop_front();
         chk("intensity_use", nt[1], intensity_use_q);
         chk("whitebal_use", nt[0], whitebal_use_q);
      end
      if (aresetn && pix_valid) begin
         col = pix_line_start || pix_frame_start ? 13'h0 : col + 13'h1;
         line = pix_frame_start ? 13'h0 : line + {12'h0, pix_line_start};
         h1 = inr(col, sh[0][0], sh[0][2]) && inr(line, sh[0][1], sh[0][3]);
         h2 = h1 && inr(col, sh[2][0], sh[2][2]) && inr(line, sh[2][1], sh[2][3]);
         h1 = h1 && inr(col, sh[1][0], sh[1][2]) && inr(line, sh[1][1], sh[1][3]);
         ei = (h1 && asn[0][0]) || (h2 && asn[1][0]);
         ew = (h1 && asn[0][1]) || (h2 && asn[1][1]);
         note_q.push_back({ei, ew});
         // Frame start closes the previous frame's activity
         if (pix_frame_start) begin
            prv_i = act_i;
            prv_w = act_w;
            act_i = 1'b0;
            act_w = 1'b0;
         end
         act_i = act_i | ei;
         act_w = act_w | ew;
      end
   end
   // Random stalls from the shared generator
   always @(posedge aclk) begin
      rnd <= nx(rnd);
      stall <= rnd[2] & rnd[5];
   end
   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end
   initial begin
      #(100 * 60000);
      failures = failures + 1;
      tally_and_finish;
   end
   initial begin
      {aresetn, go, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
      {s_axi_arvalid, s_axi_rready} = 2'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      {s_axi_wstrb, wst} = 8'hFF;
      {failures, check_count} = 64'h0;
      for (k = 0; k < 3; k++) sh[k] = '{13'h0, 13'h0, 13'h0800, 13'h0440};
      asn = '{2'h1, 2'h2};
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      axi_rd(`SWOQ_OFF_W1_COLS, 32'h00000800, 2'h0);
      axi_rd(`SWOQ_OFF_W2_LINES, 32'h00000440, 2'h0);
      axi_rd(`SWOQ_OFF_IMG_COLS, 32'h00000800, 2'h0);
      axi_rd(`SWOQ_OFF_W2_COL, 32'h0, 2'h0);
      axi_rd(`SWOQ_OFF_W1_ASSIGN, 32'h1, 2'h0);
      axi_rd(`SWOQ_OFF_W2_ASSIGN, 32'h2, 2'h0);
      axi_rd(8'h5C, 32'h0, `SWOQ_RESP_SLVERR);
      axi_wr(8'h5C, 32'h1, `SWOQ_RESP_SLVERR);
      // Low lanes disabled: answered, but nothing stored
      wst = 4'hC;
      axi_wr(`SWOQ_OFF_W1_COLS, 32'h5, `SWOQ_RESP_OKAY);
      wst = 4'hF;
      axi_rd(`SWOQ_OFF_W1_COLS, 32'h00000800, 2'h0);
      run_frame;
      axi_wr(`SWOQ_OFF_CTRL, 32'h1, 2'h0);
      @(posedge aclk);
      chk("binning", 1'b1, binning_q);
      setw(0, 13'h0, 13'h0, 13'h00C, 13'h00A);
      setw(1, 13'h010, 13'h0, 13'h4, 13'h4);
      run_frame;
      for (k = 0; k < 9; k++) begin
         setw(k % 3, 13'(rnd % 16'h18), 13'(rnd[15:8] % 8'hA), 13'(rnd[7:0] % 8'h14),
            13'(rnd[12:5] % 8'hC));
         seta(k % 2, rnd[4:3]);
         run_frame;
         axi_rd(`SWOQ_OFF_STATUS, {27'h0, emp(2), emp(1), emp(0), prv_w, prv_i}, 2'h0);
         axi_rd(`SWOQ_OFF_W1_COLS, {19'h0, sh[1][2]}, 2'h0);
      end
      run_frame;
      tally_and_finish;
   end
endmodule // swoq_qualifier_bench
bind swoq_qualifier swoq_qualifier_props u_chk (.aclk(aclk), .aresetn(aresetn),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .pix_valid(pix_valid), .pix_frame_start(pix_frame_start), .pix_valid_q(pix_valid_q),
   .intensity_use_q(intensity_use_q), .whitebal_use_q(whitebal_use_q),
   .intensity_active_q(intensity_active_q), .whitebal_active_q(whitebal_active_q));
